// ===== rtl/spcf_defs.svh
// offsets, field codes, reset values and timing counts for the serial settings manager
`ifndef SPCF_DEFS_SVH
`define SPCF_DEFS_SVH

`define SPCF_OFS_BAUD     16'h0601
`define SPCF_OFS_PARITY   16'h0602
`define SPCF_OFS_STOP     16'h0603
`define SPCF_OFS_DELAY    16'h0604
`define SPCF_OFS_COMMIT   16'h0605

`define SPCF_BAUD_9600    16'h2580
`define SPCF_BAUD_19200   16'h4b00
`define SPCF_BAUD_28800   16'h7080
`define SPCF_BAUD_38400   16'h9600
`define SPCF_BAUD_48000   16'hbb80
`define SPCF_BAUD_57600   16'he100

`define SPCF_PAR_NONE     2'h0
`define SPCF_PAR_ODD      2'h1
`define SPCF_PAR_EVEN     2'h2
`define SPCF_STOP_ONE     2'h1
`define SPCF_STOP_TWO     2'h2
`define SPCF_DATA_BITS    4'h8

`define SPCF_RST_BAUD     `SPCF_BAUD_9600
`define SPCF_RST_PARITY   `SPCF_PAR_NONE
`define SPCF_RST_STOP     `SPCF_STOP_ONE
`define SPCF_RST_DELAY    16'h0000
`define SPCF_COMMIT_GO    16'h0001
`define SPCF_SW_ZERO      8'h00

`define SPCF_CLK_NS       8
`define SPCF_MS_NS        1000000
`define SPCF_WINDOW_MIN   3
`define SPCF_WINDOW_MS    (`SPCF_WINDOW_MIN * 60 * 1000)

`endif

// ===== rtl/spcf_pkg.sv
// types shared by the serial settings manager
package spcf_pkg;

  typedef struct packed {
    logic [15:0] baud;
    logic [1:0]  parity;
    logic [1:0]  stop;
    logic [15:0] delay;
  } serial_cfg_s;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_HOLD  = 2'b01,
    CS_TRIAL = 2'b10
  } commit_state_e;

endpackage

// ===== rtl/serial_param_commit_failsafe.sv
// staged serial settings with commit, confirmation window and address-zero failsafe
`timescale 1ns/1ns
`include "spcf_defs.svh"

module serial_param_commit_failsafe #(
  parameter int CYC_PER_MS = `SPCF_MS_NS / `SPCF_CLK_NS,
  parameter int WINDOW_MS  = `SPCF_WINDOW_MS
) (
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  // register access from the frame decoder
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  input  wire logic [15:0]          REG_ADDR,
  input  wire logic [15:0]          REG_WDATA,
  output logic      [15:0]          REG_RDATA,
  output logic                      REG_ACK,
  output logic                      REG_HIT,
  output logic                      REG_EXC,
  // line events and switch
  input  wire logic [7:0]           ADDR_SW,
  input  wire logic                 QUERY_OK,
  input  wire logic                 REPLY_READY,
  output logic                      REPLY_GO,
  // settings to the bit engine and frame decoder
  output spcf_pkg::serial_cfg_s     ACTIVE_CFG,
  output logic                      ANY_ADDR,
  output logic                      BOOT_MODE,
  output logic                      CONFIRM_PENDING,
  // non-volatile store
  input  wire spcf_pkg::serial_cfg_s NV_CFG,
  output logic                      NV_SAVE,
  output spcf_pkg::serial_cfg_s     NV_DATA
);
  import spcf_pkg::*;

  localparam serial_cfg_s DEF_CFG = '{`SPCF_RST_BAUD, `SPCF_RST_PARITY, `SPCF_RST_STOP, `SPCF_RST_DELAY};

  function automatic logic baud_ok(input logic [15:0] v);
    baud_ok = (v == `SPCF_BAUD_9600) || (v == `SPCF_BAUD_19200) || (v == `SPCF_BAUD_28800) ||
              (v == `SPCF_BAUD_38400) || (v == `SPCF_BAUD_48000) || (v == `SPCF_BAUD_57600);
  endfunction

  // timebase
  logic [16:0]   ms_cnt, next_ms_cnt;
  logic          ms_tick, next_ms_tick;
  // settings state
  serial_cfg_s   staged, next_staged;
  serial_cfg_s   trial, next_trial;
  serial_cfg_s   perm, next_perm;
  commit_state_e state, next_state;
  logic [17:0]   win_cnt, next_win_cnt;
  logic          started, next_started;
  logic          boot, next_boot;
  logic          nv_save, next_nv_save;
  serial_cfg_s   active, next_active;
  logic          any_addr, next_any_addr;
  logic          pending, next_pending;
  // register answer
  logic [15:0]   rdata, next_rdata;
  logic          ack, next_ack;
  logic          hit, next_hit;
  logic          exc, next_exc;
  // reply delay
  logic          dly_busy, next_dly_busy;
  logic [15:0]   dly_cnt, next_dly_cnt;
  logic          go, next_go;

  logic          sw_zero;
  logic          commit_req;

  assign sw_zero = (ADDR_SW == `SPCF_SW_ZERO);
  assign commit_req = REG_WR && (REG_ADDR == `SPCF_OFS_COMMIT) && (REG_WDATA == `SPCF_COMMIT_GO);

  always_comb begin
    next_ms_tick = 1'b0;
    next_ms_cnt  = ms_cnt + 17'h00001;
    if (ms_cnt == 17'(CYC_PER_MS - 1)) begin
      next_ms_cnt  = 17'h00000;
      next_ms_tick = 1'b1;
    end
  end

  // register access: writes land in the staged copy only
  always_comb begin
    next_staged = staged;
    next_rdata  = 16'h0000;
    next_ack    = REG_WR || REG_RD;
    next_hit    = 1'b1;
    next_exc    = 1'b0;
    if (!started) begin
      next_staged = NV_CFG;
    end
    if (REG_ADDR == `SPCF_OFS_BAUD) begin
      next_rdata = staged.baud;
      if (REG_WR && baud_ok(REG_WDATA)) begin
        next_staged.baud = REG_WDATA;
      end else if (REG_WR) begin
        next_exc = 1'b1;
      end
    end else if (REG_ADDR == `SPCF_OFS_PARITY) begin
      next_rdata = {14'h0000, staged.parity};
      if (REG_WR && (REG_WDATA <= {14'h0000, `SPCF_PAR_EVEN})) begin
        next_staged.parity = REG_WDATA[1:0];
      end else if (REG_WR) begin
        next_exc = 1'b1;
      end
    end else if (REG_ADDR == `SPCF_OFS_STOP) begin
      next_rdata = {14'h0000, staged.stop};
      if (REG_WR && ((REG_WDATA == {14'h0000, `SPCF_STOP_ONE}) || (REG_WDATA == {14'h0000, `SPCF_STOP_TWO}))) begin
        next_staged.stop = REG_WDATA[1:0];
      end else if (REG_WR) begin
        next_exc = 1'b1;
      end
    end else if (REG_ADDR == `SPCF_OFS_DELAY) begin
      next_rdata = staged.delay;
      if (REG_WR) begin
        next_staged.delay = REG_WDATA;
      end
    end else if (REG_ADDR == `SPCF_OFS_COMMIT) begin
      next_rdata = 16'h0000;
    end else begin
      next_hit = 1'b0;
    end
    if (!next_ack) begin
      next_hit   = 1'b0;
      next_exc   = 1'b0;
      next_rdata = 16'h0000;
    end
  end

  // commit and confirmation; a commit in the same cycle as a query wins,
  // since that query was heard at the old settings
  always_comb begin
    next_trial   = trial;
    next_perm    = perm;
    next_state   = state;
    next_win_cnt = win_cnt;
    next_nv_save = 1'b0;
    next_started = 1'b1;
    next_boot    = boot;
    if (!started) begin
      next_perm = NV_CFG;
      next_boot = sw_zero;
    end
    if (commit_req) begin
      next_trial   = staged;
      next_win_cnt = 18'h00000;
      next_state   = sw_zero ? CS_HOLD : CS_TRIAL;
    end else begin
      case (state)
        CS_HOLD: begin
          if (!sw_zero) begin
            next_state   = CS_TRIAL;
            next_win_cnt = 18'h00000;
          end
        end
        CS_TRIAL: begin
          if (sw_zero) begin
            next_state = CS_HOLD;
          end else if (QUERY_OK) begin
            next_perm    = trial;
            next_nv_save = 1'b1;
            next_state   = CS_IDLE;
          end else if (ms_tick) begin
            if (win_cnt == 18'(WINDOW_MS - 1)) begin
              next_state = CS_IDLE;
            end else begin
              next_win_cnt = win_cnt + 18'h00001;
            end
          end
        end
        default: begin
          next_state = CS_IDLE;
        end
      endcase
    end
    next_active   = (next_state == CS_TRIAL) ? next_trial : next_perm;
    if (sw_zero) begin
      next_active = DEF_CFG;
    end
    next_any_addr = sw_zero;
    next_pending  = (next_state == CS_TRIAL);
  end

  // reply holdoff: delay+1 tick edges guarantee at least delay full milliseconds
  always_comb begin
    next_dly_busy = dly_busy;
    next_dly_cnt  = dly_cnt;
    next_go       = 1'b0;
    if (!dly_busy && REPLY_READY) begin
      if (active.delay == 16'h0000) begin
        next_go = 1'b1;
      end else begin
        next_dly_busy = 1'b1;
        next_dly_cnt  = active.delay;
      end
    end else if (dly_busy && ms_tick) begin
      if (dly_cnt == 16'h0000) begin
        next_go       = 1'b1;
        next_dly_busy = 1'b0;
      end else begin
        next_dly_cnt = dly_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ms_cnt   <= 17'h00000;
      ms_tick  <= 1'b0;
      staged   <= DEF_CFG;
      trial    <= DEF_CFG;
      perm     <= DEF_CFG;
      state    <= CS_IDLE;
      win_cnt  <= 18'h00000;
      started  <= 1'b0;
      boot     <= 1'b0;
      nv_save  <= 1'b0;
      active   <= DEF_CFG;
      any_addr <= 1'b0;
      pending  <= 1'b0;
      rdata    <= 16'h0000;
      ack      <= 1'b0;
      hit      <= 1'b0;
      exc      <= 1'b0;
      dly_busy <= 1'b0;
      dly_cnt  <= 16'h0000;
      go       <= 1'b0;
    end else begin
      ms_cnt   <= next_ms_cnt;
      ms_tick  <= next_ms_tick;
      staged   <= next_staged;
      trial    <= next_trial;
      perm     <= next_perm;
      state    <= next_state;
      win_cnt  <= next_win_cnt;
      started  <= next_started;
      boot     <= next_boot;
      nv_save  <= next_nv_save;
      active   <= next_active;
      any_addr <= next_any_addr;
      pending  <= next_pending;
      rdata    <= next_rdata;
      ack      <= next_ack;
      hit      <= next_hit;
      exc      <= next_exc;
      dly_busy <= next_dly_busy;
      dly_cnt  <= next_dly_cnt;
      go       <= next_go;
    end
  end

  always_comb begin
    REG_RDATA       = rdata;
    REG_ACK         = ack;
    REG_HIT         = hit;
    REG_EXC         = exc;
    REPLY_GO        = go;
    ACTIVE_CFG      = active;
    ANY_ADDR        = any_addr;
    BOOT_MODE       = boot;
    CONFIRM_PENDING = pending;
    NV_SAVE         = nv_save;
    NV_DATA         = perm;
  end

endmodule // serial_param_commit_failsafe

// ===== tb/spcf_sva.sv
// port-level assertions for the serial settings manager
`timescale 1ns/1ns
module spcf_sva (
  // clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  RST_N,
  // register access
  input wire logic                  REG_WR,
  input wire logic                  REG_RD,
  input wire logic [15:0]           REG_ADDR,
  input wire logic [15:0]           REG_WDATA,
  input wire logic                  REG_ACK,
  input wire logic                  REG_HIT,
  input wire logic                  REG_EXC,
  // line events and settings
  input wire logic [7:0]            ADDR_SW,
  input wire logic                  QUERY_OK,
  input wire logic                  REPLY_READY,
  input wire logic                  REPLY_GO,
  input wire spcf_pkg::serial_cfg_s ACTIVE_CFG,
  input wire logic                  ANY_ADDR,
  input wire logic                  CONFIRM_PENDING,
  input wire logic                  NV_SAVE
);
  import spcf_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire logic req = REG_WR || REG_RD;
  // reset term keeps the release edge out, outputs settle one edge later
  wire logic zr  = RST_N && ADDR_SW == 8'h00;
  // a reply request made while an earlier one is still held off is ignored
  logic reply_wait;
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      reply_wait <= 1'b0;
    end else if (REPLY_GO || !reply_wait) begin
      reply_wait <= REPLY_READY && ACTIVE_CFG.delay != 16'h0000;
    end
  end
  sequence commit_s;
    REG_WR && REG_ADDR == 16'h0605 && REG_WDATA == 16'h0001;
  endsequence
  sequence confirm_s;
    CONFIRM_PENDING && QUERY_OK && ADDR_SW != 8'h00 && !(REG_WR && REG_ADDR == 16'h0605);
  endsequence
  ack_follows_a: assert property (REG_ACK == $past(req))
    else $error("ack not one cycle after request");
  hit_range_a: assert property (req |=> REG_HIT == ($past(REG_ADDR) inside {[16'h0601:16'h0605]}))
    else $error("hit flag wrong");
  bad_parity_a: assert property (REG_WR && REG_ADDR == 16'h0602 && REG_WDATA > 16'h0002 |=> REG_EXC)
    else $error("bad parity accepted");
  zero_default_a: assert property (zr |=> ACTIVE_CFG.baud == 16'h2580 && ACTIVE_CFG.parity == 2'h0
    && ACTIVE_CFG.stop == 2'h1) else $error("zero switch not default");
  zero_any_a: assert property (zr |=> ANY_ADDR)
    else $error("any address off");
  zero_hold_a: assert property (zr |=> !CONFIRM_PENDING && !NV_SAVE)
    else $error("confirm at zero switch");
  commit_open_a: assert property (commit_s ##0 ADDR_SW != 8'h00 |=> CONFIRM_PENDING)
    else $error("commit did not open window");
  confirm_save_a: assert property (confirm_s |=> NV_SAVE && !CONFIRM_PENDING)
    else $error("query did not confirm");
  reply_now_a: assert property ((!reply_wait || REPLY_GO) && REPLY_READY && ACTIVE_CFG.delay == 16'h0000 |=> REPLY_GO)
    else $error("zero delay reply late");
endmodule // spcf_sva

// ===== tb/modbus_master_model.sv
// serial master: a query lands only when its port matches the device
`timescale 1ns/1ns
module modbus_master_model (
  // clock
  input  wire logic                  clk,
  // port settings and request
  input  wire spcf_pkg::serial_cfg_s port_cfg,
  input  wire spcf_pkg::serial_cfg_s dev_cfg,
  input  wire logic                  send,
  // result
  output logic                       query_ok
);
  import spcf_pkg::*;
  // no framing modelled; a mismatched port garbles the frame
  always_ff @(posedge clk) begin
    query_ok <= send && port_cfg.baud == dev_cfg.baud && port_cfg.parity == dev_cfg.parity
      && port_cfg.stop == dev_cfg.stop;
  end
endmodule // modbus_master_model

// ===== tb/testbench.sv
// self-checking bench for the serial settings manager
`timescale 1ns/1ns
module testbench;
  import spcf_pkg::*;
  `define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
  typedef struct packed {logic [15:0] a; logic [15:0] d; logic h; logic e;} row_s;
  localparam serial_cfg_s DEF = '{16'h2580, 2'h0, 2'h1, 16'h0000};
  localparam serial_cfg_s NEW = '{16'he100, 2'h2, 2'h2, 16'h0005};
  row_s rows [16] = '{
    '{16'h0601, 16'h4b00, 1'b1, 1'b0}, '{16'h0601, 16'h7080, 1'b1, 1'b0}, '{16'h0601, 16'h9600, 1'b1, 1'b0},
    '{16'h0601, 16'hbb80, 1'b1, 1'b0}, '{16'h0601, 16'h2580, 1'b1, 1'b0}, '{16'h0601, 16'he100, 1'b1, 1'b0},
    '{16'h0601, 16'h1234, 1'b1, 1'b1}, '{16'h0602, 16'h0001, 1'b1, 1'b0}, '{16'h0602, 16'h0000, 1'b1, 1'b0},
    '{16'h0602, 16'h0002, 1'b1, 1'b0}, '{16'h0602, 16'h0003, 1'b1, 1'b1}, '{16'h0603, 16'h0001, 1'b1, 1'b0},
    '{16'h0603, 16'h0002, 1'b1, 1'b0}, '{16'h0603, 16'h0000, 1'b1, 1'b1}, '{16'h0604, 16'h0005, 1'b1, 1'b0},
    '{16'h0606, 16'h0000, 1'b0, 1'b0}};
  logic [15:0] rb [4] = '{16'he100, 16'h0002, 16'h0002, 16'h0005};
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rr = 1'b0, send = 1'b0;
  logic        ack, hit, exc, go, any, boot, pend, save, qok;
  logic [7:0]  sw = 8'h01;
  logic [15:0] addr = 16'h0000, wd = 16'h0000, rdata;
  serial_cfg_s act, nvd, nv = DEF, mcfg = DEF;
  int          err_total = 0, checks = 0, c;

  serial_param_commit_failsafe #(.CYC_PER_MS(10), .WINDOW_MS(5)) u_dut (
    .CLK_SYS(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_RDATA(rdata), .REG_ACK(ack), .REG_HIT(hit), .REG_EXC(exc), .ADDR_SW(sw), .QUERY_OK(qok),
    .REPLY_READY(rr), .REPLY_GO(go), .ACTIVE_CFG(act), .ANY_ADDR(any), .BOOT_MODE(boot),
    .CONFIRM_PENDING(pend), .NV_CFG(nv), .NV_SAVE(save), .NV_DATA(nvd));
  modbus_master_model u_master (.clk(clk), .port_cfg(mcfg), .dev_cfg(act), .send(send), .query_ok(qok));

  initial forever #4 clk = ~clk;
  // permanent store keeps what the device saves
  always @(negedge clk) if (save === 1'b1) nv <= nvd;

  task automatic report_and_stop;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_op(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic await(input int sel, input int lim);
    c = 0;
    while ((sel == 0 ? go : sel == 1 ? save : !pend) !== 1'b1) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask
  task automatic reboot;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    reboot();
    `CHK("cfg", DEF, act)
    `CHK("boot", 1'b0, boot)
    `CHK("any", 1'b0, any)
    pulse(rr);
    await(0, 3);
    foreach (rows[i]) begin
      reg_op(1'b1, rows[i].a, rows[i].d);
      `CHK("hit", rows[i].h, hit && ack)
      `CHK("ack", 1'b1, ack)
      `CHK("exc", rows[i].e, exc)
    end
    for (int i = 0; i < 4; i++) begin
      reg_op(1'b0, 16'h0601 + 16'(i), 16'h0000);
      `CHK("rdata", rb[i], rdata)
    end
    `CHK("staged", DEF, act)
    reg_op(1'b1, 16'h0605, 16'h0001);
    `CHK("trial", NEW, act)
    mcfg = NEW;
    pulse(send);
    await(1, 5);
    `CHK("saved", NEW, nvd)
    `CHK("pend", 1'b0, pend)
    pulse(rr);
    await(0, 80);
    `CHK("delay", 1'b1, c >= 50 && c <= 62)
    reg_op(1'b1, 16'h0601, 16'h4b00);
    reg_op(1'b1, 16'h0605, 16'h0001);
    pulse(send);
    await(2, 70);
    `CHK("window", 1'b1, c >= 38)
    `CHK("revert", NEW, act)
    reg_op(1'b1, 16'h0605, 16'h0002);
    `CHK("nocommit", 1'b0, pend)
    `CHK("nocommit", NEW, act)
    reg_op(1'b1, 16'h0605, 16'h0001);
    reboot();
    `CHK("reboot", NEW, act)
    sw = 8'h00;
    repeat (2) @(negedge clk);
    `CHK("zero", DEF, act)
    `CHK("any", 1'b1, any)
    reg_op(1'b1, 16'h0601, 16'h4b00);
    reg_op(1'b1, 16'h0605, 16'h0001);
    mcfg = DEF;
    pulse(send);
    repeat (2) @(negedge clk);
    `CHK("held", 1'b0, pend)
    `CHK("kept", NEW, nv)
    sw = 8'h01;
    repeat (2) @(negedge clk);
    `CHK("open", 16'h4b00, act.baud)
    sw = 8'h00;
    repeat (2) @(negedge clk);
    `CHK("rehold", 1'b0, pend)
    `CHK("rehold", DEF, act)
    reboot();
    `CHK("boot", 1'b1, boot)
    reg_op(1'b1, 16'h0602, 16'h0001);
    `CHK("bootwr", 1'b0, exc)
    `CHK("bootwr", 1'b1, hit)
    reg_op(1'b1, 16'h0605, 16'h0001);
    sw = 8'h01;
    repeat (2) @(negedge clk);
    `CHK("bootcommit", 2'h1, act.parity)
    `CHK("bootstay", 1'b1, boot)
    report_and_stop();
  end
endmodule // testbench

bind serial_param_commit_failsafe spcf_sva u_sva (.CLK_SYS, .RST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
  .REG_ACK, .REG_HIT, .REG_EXC, .ADDR_SW, .QUERY_OK, .REPLY_READY, .REPLY_GO, .ACTIVE_CFG, .ANY_ADDR,
  .CONFIRM_PENDING, .NV_SAVE);
